// File: verilog/oob_device.sv
`timescale 1ns/100ps
module oob_device (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // link
  oob_link_if.device             link,
  // user side
  input  wire logic              wake_req,
  input  wire logic              pm_partial_req,
  input  wire logic              pm_slumber_req,
  input  wire logic              recover_req,
  input  wire logic              activity,
  input  wire oob_pkg::rate_e    neg_rate,
  output logic                   phy_ready,
  output logic                   in_partial,
  output logic                   in_slumber,
  output logic                   spinup_en,
  output logic [oob_pkg::TMR_W-1:0] wake_cycles
);
  import oob_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {S_RESET, S_INIT, S_ALIGN, S_READY, S_PARTIAL, S_SLUMBER,
                            S_DWAKE, S_NOCOMM} st_e;
  st_e              st;
  logic [3:0]       burst_cnt;
  logic [3:0]       gap_cnt;
  logic [TMR_W-1:0] tmr;
  logic             recovering;
  rate_e            rate;
  logic             strap_done;

  wire logic tick = clk_en && gap_cnt == 4'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st         <= S_RESET;
      burst_cnt  <= 4'h0;
      gap_cnt    <= 4'h0;
      recovering <= 1'b0;
      link.d2h_oob <= OOB_NONE;
      link.d2h_pm  <= PM_NONE;
      link.d2h_sig <= 1'b0;
    end else if (clk_en) begin
      link.d2h_oob <= OOB_NONE;
      link.d2h_sig <= 1'b0;
      gap_cnt <= (gap_cnt != 4'h0) ? gap_cnt - 4'h1 : 4'h0;
      unique case (st)
        S_RESET: if (link.h2d_oob == OOB_RESET) begin
          st <= S_INIT;
          burst_cnt <= 4'h0;
        end
        S_INIT: if (tick) begin
          link.d2h_oob <= OOB_INIT;
          gap_cnt <= gap_cycles(OOB_INIT);
          burst_cnt <= burst_cnt + 4'h1;
          if (burst_cnt == 4'(BURSTS - 1)) begin
            st <= S_ALIGN;
            burst_cnt <= 4'h0;
          end
        end
        S_ALIGN: begin
          if (link.h2d_oob == OOB_WAKE)
            burst_cnt <= burst_cnt + 4'h1;
          if (burst_cnt >= 4'(WAKE_CYC)) begin
            st <= S_READY;
            link.d2h_sig <= recovering;
            recovering <= 1'b0;
          end
        end
        S_READY: begin
          link.d2h_pm <= PM_NONE;
          if (link.h2d_oob == OOB_RESET) begin
            st <= S_INIT;
            burst_cnt <= 4'h0;
          end else if (recover_req) begin
            st <= S_NOCOMM;
          end else if (link.h2d_pm == PM_PARTIAL || link.h2d_pm == PM_SLUMBER) begin
            link.d2h_pm <= PM_ACK;
            st <= (link.h2d_pm == PM_PARTIAL) ? S_PARTIAL : S_SLUMBER;
          end else if (link.h2d_pm == PM_ACK && link.d2h_pm != PM_NONE) begin
            // own request acknowledged: enter the state that was asked for
            st <= (link.d2h_pm == PM_PARTIAL) ? S_PARTIAL : S_SLUMBER;
          end else if (pm_partial_req) begin
            link.d2h_pm <= PM_PARTIAL;
          end else if (pm_slumber_req) begin
            link.d2h_pm <= PM_SLUMBER;
          end
        end
        S_PARTIAL, S_SLUMBER: begin
          link.d2h_pm <= PM_NONE;
          if (link.h2d_oob == OOB_WAKE) begin
            st <= S_ALIGN;
            burst_cnt <= 4'h0;
          end else if (link.h2d_oob == OOB_RESET) begin
            st <= S_INIT;
            burst_cnt <= 4'h0;
          end else if (wake_req) begin
            st <= S_DWAKE;
            burst_cnt <= 4'h0;
          end
        end
        S_DWAKE: if (link.h2d_oob == OOB_WAKE) begin
          // host answered: its first wake counts toward alignment
          st <= S_ALIGN;
          burst_cnt <= 4'h1;
        end else if (tick) begin
          link.d2h_oob <= OOB_WAKE;
          gap_cnt <= gap_cycles(OOB_WAKE);
          burst_cnt <= burst_cnt + 4'h1;
          if (burst_cnt == 4'(BURSTS - 1)) begin
            st <= S_ALIGN;
            burst_cnt <= 4'h0;
          end
        end
        S_NOCOMM: begin
          // one unsolicited init, then wait for the host's reset sequence
          link.d2h_oob <= OOB_INIT;
          gap_cnt <= gap_cycles(OOB_INIT);
          recovering <= 1'b1;
          st <= S_RESET;
          burst_cnt <= 4'h0;
        end
      endcase
    end
  end

  // ****************************************
  // align at the rate caught at power-on
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rate <= RATE_NONE;
      link.d2h_align <= 1'b0;
      link.d2h_rate  <= RATE_NONE;
    end else if (clk_en) begin
      if (rate == RATE_NONE && st == S_ALIGN)
        rate <= neg_rate;
      // align only once the wakes are counted, so the host keeps waking until then
      link.d2h_align <= (st == S_ALIGN && burst_cnt >= 4'(WAKE_CYC)) || st == S_READY;
      link.d2h_rate  <= (rate == RATE_NONE) ? neg_rate : rate;
    end
  end

  // ****************************************
  // wake-to-ready timer
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tmr <= '0;
      wake_cycles <= '0;
    end else if (clk_en) begin
      if (st == S_PARTIAL || st == S_SLUMBER)
        tmr <= '0;
      else if (st != S_READY && tmr != '1)
        tmr <= tmr + 1'b1;
      if (st == S_ALIGN && burst_cnt >= 4'(WAKE_CYC))
        wake_cycles <= tmr;
    end
  end

  // ****************************************
  // spinup/activity pin and status
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      strap_done <= 1'b0;
      spinup_en  <= 1'b1;
      link.pin_dev_out  <= 1'b1;
      link.pin_dev_oe_n <= 1'b1;
      phy_ready  <= 1'b0;
      in_partial <= 1'b0;
      in_slumber <= 1'b0;
    end else if (clk_en) begin
      if (!strap_done) begin
        spinup_en <= link.pin_level;
        if (st == S_READY)
          strap_done <= 1'b1;
      end
      link.pin_dev_oe_n <= !strap_done;
      link.pin_dev_out  <= !activity;
      phy_ready  <= (st == S_READY);
      in_partial <= (st == S_PARTIAL);
      in_slumber <= (st == S_SLUMBER);
    end
  end
endmodule

// File: verilog/oob_pkg.sv
// Notes on behaviour
// - three OOB kinds: reset, init, wake
// - wake burst exits partial or slumber
// - burst and gap use 106.7/320 ns
// - ready state: phy synced, data flows
// - partial: lines idle, exit within 10 us
// - slumber: reduced power, exit within 10 ms
// - host wakeup enters at host-wake point
// - device wakeup enters at device-wake point
// - after wake, align at negotiated rate
// - slumber entry mirrors partial request handshake
// - spinup pin input before ready, output after
// - activity-accepting host never drives spinup pin
// - signal loss is ready dropping into nocomm
// - device recovery comminit returns signature
// - host answers unsolicited comminit with comreset
// - recovery comreset loads shadow 7F/FF
// - cominit reply sets shadow status 80
package oob_pkg;
  localparam int CLK_PERIOD_PS    = 100000;
  localparam int SHORT_IVAL_PS    = 106700;
  localparam int LONG_IVAL_PS     = 320000;
  localparam int PARTIAL_EXIT_NS  = 10000;
  localparam int SLUMBER_EXIT_NS  = 10000000;
  localparam int SHORT_CYC = (SHORT_IVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LONG_CYC  = (LONG_IVAL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PARTIAL_EXIT_CYC = PARTIAL_EXIT_NS / (CLK_PERIOD_PS / 1000);
  localparam int SLUMBER_EXIT_CYC = SLUMBER_EXIT_NS / (CLK_PERIOD_PS / 1000);
  localparam int BURSTS       = 6;
  localparam int WAKE_CYC     = 4;
  localparam int ALIGN_CYC    = 8;
  localparam int TMR_W        = 24;
  localparam logic [7:0] SHADOW_STATUS_RST = 8'h7F;
  localparam logic [7:0] SHADOW_OTHER_RST  = 8'hFF;
  localparam logic [7:0] SHADOW_ATTACHED   = 8'h80;
  localparam logic [7:0] SIGNATURE         = 8'h50;  // arbitrary value

  typedef enum logic [1:0] {OOB_NONE, OOB_RESET, OOB_INIT, OOB_WAKE} oob_kind_e;
  typedef enum logic [1:0] {PM_NONE, PM_PARTIAL, PM_SLUMBER, PM_ACK} pm_prim_e;
  typedef enum logic [1:0] {RATE_G1, RATE_G2, RATE_G3, RATE_NONE} rate_e;

  // gap length distinguishes the kinds: reset/init long, wake short
  function automatic logic [3:0] gap_cycles(input oob_kind_e k);
    gap_cycles = (k == OOB_WAKE) ? 4'(SHORT_CYC) : 4'(LONG_CYC);
  endfunction
endpackage

// File: verilog/oob_link_if.sv
`timescale 1ns/100ps
interface oob_link_if;
  import oob_pkg::*;
  oob_kind_e h2d_oob;
  oob_kind_e d2h_oob;
  pm_prim_e  h2d_pm;
  pm_prim_e  d2h_pm;
  logic      d2h_align;
  rate_e     d2h_rate;
  logic      d2h_sig;
  logic      pin_host_out;
  logic      pin_host_oe_n;
  logic      pin_dev_out;
  logic      pin_dev_oe_n;
  logic      pin_level;
  assign pin_level = !pin_dev_oe_n ? pin_dev_out : (!pin_host_oe_n ? pin_host_out : 1'b1);
  modport device (input h2d_oob, h2d_pm, pin_level,
                  output d2h_oob, d2h_pm, d2h_align, d2h_rate, d2h_sig, pin_dev_out, pin_dev_oe_n);
  modport host (input d2h_oob, d2h_pm, d2h_align, d2h_rate, d2h_sig, pin_level,
                output h2d_oob, h2d_pm, pin_host_out, pin_host_oe_n);
endinterface

// File: verilog/oob_host.sv
`timescale 1ns/100ps
module oob_host (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // link
  oob_link_if.host        link,
  // user side
  input  wire logic       start_reset,
  input  wire logic       wake_req,
  input  wire logic       pm_partial_req,
  input  wire logic       pm_slumber_req,
  input  wire logic       use_activity,
  input  wire logic       spinup_disable,
  output logic            phy_ready,
  output logic            low_power,
  output logic            activity_seen,
  output logic [7:0]      shadow_status,
  output logic [7:0]      shadow_other
);
  import oob_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {H_IDLE, H_RESET, H_AWAIT_INIT, H_WAKE, H_READY, H_LOW} hst_e;
  hst_e       st;
  logic [3:0] burst_cnt;
  logic [3:0] gap_cnt;

  wire logic tick = gap_cnt == 4'h0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= H_IDLE;
      burst_cnt <= 4'h0;
      gap_cnt <= 4'h0;
      shadow_status <= SHADOW_STATUS_RST;
      shadow_other  <= SHADOW_OTHER_RST;
      link.h2d_oob <= OOB_NONE;
      link.h2d_pm  <= PM_NONE;
    end else if (clk_en) begin
      link.h2d_oob <= OOB_NONE;
      gap_cnt <= (gap_cnt != 4'h0) ? gap_cnt - 4'h1 : 4'h0;
      if (link.d2h_oob == OOB_INIT && st != H_AWAIT_INIT && st != H_RESET) begin
        st <= H_RESET;
        burst_cnt <= 4'h0;
        shadow_status <= SHADOW_STATUS_RST;
        shadow_other  <= SHADOW_OTHER_RST;
      end else begin
        unique case (st)
          H_IDLE: if (start_reset) begin
            st <= H_RESET;
            burst_cnt <= 4'h0;
          end
          H_RESET: if (tick) begin
            link.h2d_oob <= OOB_RESET;
            gap_cnt <= gap_cycles(OOB_RESET);
            burst_cnt <= burst_cnt + 4'h1;
            if (burst_cnt == 4'(BURSTS - 1))
              st <= H_AWAIT_INIT;
          end
          H_AWAIT_INIT: if (link.d2h_oob == OOB_INIT) begin
            shadow_status <= SHADOW_ATTACHED;
            st <= H_WAKE;
            burst_cnt <= 4'h0;
          end
          H_WAKE: if (link.d2h_align) begin
            st <= H_READY;
          end else if (tick && burst_cnt != 4'(BURSTS)) begin
            link.h2d_oob <= OOB_WAKE;
            gap_cnt <= gap_cycles(OOB_WAKE);
            burst_cnt <= burst_cnt + 4'h1;
          end
          H_READY: begin
            link.h2d_pm <= PM_NONE;
            if (link.d2h_pm == PM_PARTIAL || link.d2h_pm == PM_SLUMBER) begin
              link.h2d_pm <= PM_ACK;
              st <= H_LOW;
            end else if (link.d2h_pm == PM_ACK) begin
              st <= H_LOW;
            end else if (pm_partial_req) begin
              link.h2d_pm <= PM_PARTIAL;
            end else if (pm_slumber_req) begin
              link.h2d_pm <= PM_SLUMBER;
            end else if (!link.d2h_align && !phy_ready) begin
              st <= H_READY;
            end
          end
          H_LOW: begin
            link.h2d_pm <= PM_NONE;
            if (wake_req || link.d2h_oob == OOB_WAKE) begin
              st <= H_WAKE;
              burst_cnt <= 4'h0;
            end
          end
          default: st <= H_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // status and pin
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phy_ready <= 1'b0;
      low_power <= 1'b0;
      activity_seen <= 1'b0;
      link.pin_host_out  <= 1'b1;
      link.pin_host_oe_n <= 1'b1;
    end else if (clk_en) begin
      phy_ready <= (st == H_READY);
      low_power <= (st == H_LOW);
      activity_seen <= use_activity && phy_ready && !link.pin_level;
      link.pin_host_out  <= 1'b0;
      // release as soon as the device aligns, before it starts driving the pin
      link.pin_host_oe_n <= use_activity || !spinup_disable || link.d2h_align || phy_ready;
    end
  end
endmodule

// File: testbench/oob_link_props.sv
`timescale 1ns/100ps
module oob_link_props (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              sys_rst,
  // link
  input wire oob_pkg::oob_kind_e h2d_oob,
  input wire oob_pkg::oob_kind_e d2h_oob,
  input wire oob_pkg::pm_prim_e  h2d_pm,
  input wire oob_pkg::pm_prim_e  d2h_pm,
  input wire logic              d2h_align,
  input wire oob_pkg::rate_e     d2h_rate,
  input wire logic              d2h_sig,
  input wire logic              pin_host_oe_n,
  input wire logic              pin_dev_oe_n
);
  import oob_pkg::*;
  logic [7:0] since_init;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // cycles since the last init burst, saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst || d2h_oob == OOB_INIT)
      since_init <= 8'h00;
    else if (since_init != 8'hFF)
      since_init <= since_init + 8'h01;
  end
  chk_wake_short_gap: assert property (h2d_oob == OOB_WAKE |=> h2d_oob == OOB_NONE)
    else $error("wake burst gap too short");
  chk_reset_long_gap: assert property (h2d_oob == OOB_RESET |=> h2d_oob == OOB_NONE [*3])
    else $error("reset burst gap too short");
  chk_init_long_gap: assert property (d2h_oob == OOB_INIT |=> d2h_oob == OOB_NONE [*3])
    else $error("init burst gap too short");
  chk_dev_pm_ack: assert property (h2d_pm inside {PM_PARTIAL, PM_SLUMBER} && d2h_pm != PM_ACK
    |-> ##[1:4] d2h_pm == PM_ACK)
    else $error("device did not acknowledge power request");
  chk_host_pm_ack: assert property (d2h_pm inside {PM_PARTIAL, PM_SLUMBER} && h2d_pm != PM_ACK
    |-> ##[1:4] h2d_pm == PM_ACK)
    else $error("host did not acknowledge power request");
  chk_pin_one_driver: assert property (!(!pin_dev_oe_n && !pin_host_oe_n))
    else $error("both ends drive the shared pin");
  chk_sig_after_init: assert property (d2h_sig |-> since_init < 8'd100)
    else $error("signature without preceding init sequence");
  chk_align_rate: assert property (d2h_align |-> d2h_rate != RATE_NONE)
    else $error("align sent without negotiated rate");
  cov_wake:  cover property (h2d_oob == OOB_WAKE ##3 h2d_oob == OOB_WAKE);
  cov_ack:   cover property (d2h_pm == PM_ACK);
  cov_sig:   cover property (d2h_sig);
endmodule

// File: testbench/tb_sata_oob_phy_power_control.sv
`timescale 1ns/100ps
module tb_sata_oob_phy_power_control;
  import oob_pkg::*;
  logic        sys_clk, sys_rst, h_start, h_wake, h_part, h_slum, d_wake, d_part, d_slum;
  logic        recover, activity, h_ready, low_power, act_seen, d_ready, in_partial, in_slumber;
  logic        spinup_en, sig_seen, rst_seen, s7f_seen;
  logic        h_use_act, h_spin_dis;
  logic [7:0]  shadow_status, shadow_other;
  logic [23:0] wake_cycles;
  rate_e       neg_rate, up_rate;
  int          miscompares, n_checks, cycles;
  oob_link_if link ();
  oob_host i_oob_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
    .start_reset(h_start), .wake_req(h_wake), .pm_partial_req(h_part), .pm_slumber_req(h_slum),
    .use_activity(h_use_act), .spinup_disable(h_spin_dis), .phy_ready(h_ready), .low_power(low_power),
    .activity_seen(act_seen), .shadow_status(shadow_status), .shadow_other(shadow_other));
  oob_device i_oob_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1), .link(link),
    .wake_req(d_wake), .pm_partial_req(d_part), .pm_slumber_req(d_slum), .recover_req(recover),
    .activity(activity), .neg_rate(neg_rate), .phy_ready(d_ready), .in_partial(in_partial),
    .in_slumber(in_slumber), .spinup_en(spinup_en), .wake_cycles(wake_cycles));
  oob_link_props i_oob_link_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .h2d_oob(link.h2d_oob), .d2h_oob(link.d2h_oob), .h2d_pm(link.h2d_pm), .d2h_pm(link.d2h_pm),
    .d2h_align(link.d2h_align), .d2h_rate(link.d2h_rate), .d2h_sig(link.d2h_sig),
    .pin_host_oe_n(link.pin_host_oe_n), .pin_dev_oe_n(link.pin_dev_oe_n));
  // ****************************************
  // clock, monitors, timeout
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (link.d2h_sig === 1'b1) sig_seen = 1'b1;
    if (link.h2d_oob === OOB_RESET) rst_seen = 1'b1;
    if (shadow_status === 8'h7F && shadow_other === 8'hFF) s7f_seen = 1'b1;
  end
  always @(negedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  // ****************************************
  // tasks and expectations
  // ****************************************
  function automatic logic [23:0] exit_limit(input logic slumber);
    exit_limit = slumber ? 24'(SLUMBER_EXIT_CYC) : 24'(PARTIAL_EXIT_CYC);
  endfunction
  function automatic logic [7:0] exp_shadow(input logic attached);
    exp_shadow = attached ? SHADOW_ATTACHED : SHADOW_STATUS_RST;
  endfunction
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 400 && !(h_ready === 1'b1 && d_ready === 1'b1); i++) @(negedge sys_clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {h_start, h_wake, h_part, h_slum, d_wake, d_part, d_slum, recover, activity} = '0;
    {sig_seen, rst_seen, s7f_seen} = '0;
    h_use_act = 1'b0;
    h_spin_dis = 1'b1;
    sys_rst = 1'b1;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(32'heba6));
    neg_rate = rate_e'($urandom_range(2, 0));
    repeat (20) @(negedge sys_clk);
    sys_rst = 1'b0;
    check("reset shadow status", shadow_status, 8'h7F);
    check("reset shadow other", shadow_other, 8'hFF);
    check("reset spinup", spinup_en, 1'b1);
    check("reset ready", d_ready, 1'b0);
    $display("test reset done");
    h_start = 1'b1;
    @(negedge sys_clk);
    h_start = 1'b0;
    wait_ready();
    check("align", link.d2h_align, 1'b1);
    check("rate", link.d2h_rate, neg_rate);
    check("attached", shadow_status, exp_shadow(1'b1));
    check("spinup sampled", spinup_en, 1'b0);
    // host moves to activity use; later wakes must keep the power-on rate
    h_use_act = 1'b1;
    up_rate = neg_rate;
    neg_rate = rate_e'((int'(neg_rate) + 1) % 3);
    $display("test link up done");
    for (int k = 0; k < 4; k++) begin
      {d_part, d_slum, h_part, h_slum} = k[1] ? {!k[0], k[0], 2'b00} : {2'b00, !k[0], k[0]};
      for (int i = 0; i < 100 && low_power !== 1'b1; i++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
      {d_part, d_slum, h_part, h_slum} = '0;
      check("low state", k[0] ? in_slumber : in_partial, 1'b1);
      check("host low", low_power, 1'b1);
      if (k[1]) d_wake = 1'b1;
      else h_wake = 1'b1;
      @(negedge sys_clk);
      {d_wake, h_wake} = '0;
      wait_ready();
      check("woke", d_ready, 1'b1);
      check("exit time", 24'(wake_cycles <= exit_limit(k[0])), 24'h1);
      check("wake rate", link.d2h_rate, up_rate);
    end
    $display("test power states done");
    for (int j = 0; j < 8; j++) begin
      activity = 1'(j < 2 ? j : $urandom);
      repeat (4) @(negedge sys_clk);
      check("activity", act_seen, activity);
      check("host pin released", link.pin_host_oe_n, 1'b1);
    end
    $display("test activity done");
    {sig_seen, rst_seen, s7f_seen} = '0;
    recover = 1'b1;
    @(negedge sys_clk);
    recover = 1'b0;
    for (int i = 0; i < 20 && d_ready === 1'b1; i++) @(negedge sys_clk);
    wait_ready();
    repeat (4) @(negedge sys_clk);
    check("host comreset", rst_seen, 1'b1);
    check("shadow loaded", s7f_seen, 1'b1);
    check("signature", sig_seen, 1'b1);
    check("recovered status", shadow_status, exp_shadow(1'b1));
    $display("test recovery done");
    final_report();
  end
endmodule
